/* common/i2c_stat_pkg.sv */
package i2c_stat_pkg;
	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] INT_STATUS_OFS = 8'h04;
	localparam logic [7:0] INT_MASK_OFS = 8'h08;
	localparam logic [7:0] BUS_STATE_STATUS_OFS = 8'h18;
	localparam logic [7:0] SCL_TIMING_CONTROL_OFS = 8'h1C;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] BUS_STATE_STATUS_RST = 16'h0002;
	localparam logic [15:0] SCL_TIMING_CONTROL_RST = 16'h0000;
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam logic [3:0] INT_RST = 4'h0;
	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_PEC_BIT = 1;
	localparam int CTRL_SMB_TYPE_BIT = 2;
	localparam int CTRL_ARP_BIT = 3;
	localparam int CTRL_BCAST_BIT = 4;
	// ----------------------------------------
	// Interrupt status fields
	// ----------------------------------------
	localparam int INT_STOP_BIT = 0;
	localparam int INT_START_BIT = 1;
	localparam int INT_ADDR_BIT = 2;
	localparam int INT_ARB_BIT = 3;
	// ----------------------------------------
	// Bus state status fields
	// ----------------------------------------
	localparam int PEC_LSB = 8;
	localparam int SECOND_HIT_BIT = 7;
	localparam int HOST_HIT_BIT = 6;
	localparam int DEFAULT_HIT_BIT = 5;
	localparam int BCAST_HIT_BIT = 4;
	localparam int DIRECTION_BIT = 2;
	localparam int BUSY_BIT = 1;
	localparam int ROLE_BIT = 0;
	// ----------------------------------------
	// SCL timing fields and duty factors
	// ----------------------------------------
	localparam int SPEED_BIT = 15;
	localparam int DUTY_BIT = 14;
	localparam int DIV_W = 12;
	localparam logic [15:0] TIMING_WMASK = 16'hCFFF;
	localparam int MUL_FAST2_LOW = 2;
	localparam int MUL_FAST169_LOW = 16;
	localparam int MUL_FAST169_HIGH = 9;
	// ----------------------------------------
	// Address phase report from the byte engine
	// ----------------------------------------
	typedef struct packed {
		logic done;       // Address phase complete pulse
		logic rw;         // Read/write bit of address byte
		logic second;     // Matched own address two
		logic host;       // SMBus host address seen
		logic dflt;       // SMBus device default address seen
		logic bcast;      // General call address seen
	} addr_event_t;
endpackage

/* hw/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Asynchronous levels in, synchronised out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	// ----------------------------------------
	// Two-flop synchroniser per bit
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_reg; // First stage, read only by second
			always_ff @(posedge clk_in) begin
				if (!nrst_in) begin
					meta_reg <= 1'b1;
					sync_out[i] <= 1'b1;
				end else begin
					meta_reg <= async_in[i];
					sync_out[i] <= meta_reg;
				end
			end
		end
	endgenerate
endmodule

/* hw/scl_period_gen.sv */
`timescale 1ns/1ps
module scl_period_gen
	import i2c_stat_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Timing settings
	input wire logic run_in,
	input wire logic speed_in,
	input wire logic duty_in,
	input wire logic [DIV_W-1:0] div_in,
	// Pull SCL low while high
	output logic scl_low_out
);
	logic [15:0] low_len; // Low period in clocks
	logic [15:0] high_len; // High period in clocks
	logic [15:0] cnt_reg; // Clocks spent in phase
	logic [15:0] len; // Length of current phase

	// ----------------------------------------
	// Period lengths from divider and duty
	// ----------------------------------------
	always_comb begin
		low_len = 16'(div_in);
		high_len = 16'(div_in);
		if (speed_in && duty_in) begin
			low_len = 16'(div_in) * 16'(MUL_FAST169_LOW);
			high_len = 16'(div_in) * 16'(MUL_FAST169_HIGH);
		end else if (speed_in) begin
			low_len = 16'(div_in) * 16'(MUL_FAST2_LOW);
		end
		len = scl_low_out ? low_len : high_len;
	end

	// ----------------------------------------
	// Phase counter; high phase counts from
	// release so it holds the rise time too
	// ----------------------------------------
	// counted, no filter
	always_ff @(posedge clk_in) begin
		if (!nrst_in || !run_in) begin
			cnt_reg <= 16'h0000;
			scl_low_out <= 1'b0;
		end else if (cnt_reg + 16'h0001 >= len) begin
			cnt_reg <= 16'h0000;
			scl_low_out <= ~scl_low_out;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
		end
	end
endmodule

/* hw/i2c_status_timing.sv */
`timescale 1ns/1ps
module i2c_status_timing
	import i2c_stat_pkg::*;
(
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic NRST_IN,
	// Avalon-MM slave
	input wire logic [7:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	// Interrupt
	output logic IRQ_OUT,
	// Bus pins
	input wire logic SDA_IN,
	input wire logic SCL_IN,
	output logic SCL_OUT,
	output logic SCL_OE_OUT,
	// Byte engine reports
	input wire i2c_stat_pkg::addr_event_t ADDR_EVENT_IN,
	input wire logic START_SENT_IN,
	input wire logic ARB_LOST_IN,
	input wire logic [7:0] PEC_VALUE_IN
);
	logic [1:0] pins_sync; // Synchronised {sda, scl}
	logic sda_s, scl_s, sda_prev_reg; // Line levels
	logic start_det, stop_det; // Bus conditions
	logic restart; // Start seen while busy
	logic [4:0] ctrl_reg; // Control bits
	logic enable; // Interface enable
	logic [3:0] int_status_reg, int_status_next; // Sticky events
	logic [3:0] int_mask_reg; // Event mask
	logic [3:0] events; // Event pulses this cycle
	logic [15:0] timing_reg; // SCL timing control
	logic busy_reg; // Bus busy
	logic role_reg; // Controller role
	logic dir_reg; // Transfer direction
	logic second_reg, host_reg, dflt_reg, bcast_reg; // Hits
	logic flag_clr; // Clear for address hit flags
	logic [15:0] status; // Bus state status word
	logic req, ack_reg; // Bus request and answer
	logic wr_ack, rd_ack; // Write completes, read taken
	logic scl_low; // Generator pulls SCL low

	// ----------------------------------------
	// Pin synchronisation and conditions
	// ----------------------------------------
	pin_sync #(.W(2)) u_sync (
		.clk_in(CLK_IN),
		.nrst_in(NRST_IN),
		.async_in({SDA_IN, SCL_IN}),
		.sync_out(pins_sync)
	);
	assign sda_s = pins_sync[1];
	assign scl_s = pins_sync[0];

	// Previous SDA level for edge detection
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			sda_prev_reg <= 1'b1;
		end else begin
			sda_prev_reg <= sda_s;
		end
	end

	// Start: SDA falls while SCL high; stop: rises
	assign start_det = scl_s && sda_prev_reg && !sda_s;
	assign stop_det = scl_s && !sda_prev_reg && sda_s;
	assign restart = start_det && busy_reg;
	assign enable = ctrl_reg[CTRL_ENABLE_BIT];

	// ----------------------------------------
	// Avalon-MM handshake: one wait cycle
	// ----------------------------------------
	assign req = AVS_READ_IN || AVS_WRITE_IN;
	assign AVS_WAITREQUEST_OUT = req && !ack_reg;
	assign wr_ack = AVS_WRITE_IN && ack_reg;
	assign rd_ack = AVS_READ_IN && !ack_reg;

	// Answer flag rises one cycle after request
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req && !ack_reg;
		end
	end

	// Read data captured in the wait cycle
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			AVS_READDATA_OUT <= 32'h00000000;
		end else if (rd_ack) begin
			unique case (AVS_ADDRESS_IN)
				CTRL_OFS: AVS_READDATA_OUT <= 32'(ctrl_reg);
				INT_STATUS_OFS: AVS_READDATA_OUT <= 32'(int_status_reg);
				INT_MASK_OFS: AVS_READDATA_OUT <= 32'(int_mask_reg);
				BUS_STATE_STATUS_OFS: AVS_READDATA_OUT <= 32'(status);
				SCL_TIMING_CONTROL_OFS: AVS_READDATA_OUT <= 32'(timing_reg);
				// Unmapped reads return zero
				default: AVS_READDATA_OUT <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	// Control and mask writes
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			ctrl_reg <= CTRL_RST;
			int_mask_reg <= INT_RST;
		end else if (wr_ack) begin
			if (AVS_ADDRESS_IN == CTRL_OFS) begin
				ctrl_reg <= AVS_WRITEDATA_IN[4:0];
			end
			if (AVS_ADDRESS_IN == INT_MASK_OFS) begin
				int_mask_reg <= AVS_WRITEDATA_IN[3:0];
			end
		end
	end

	// Timing register; writes while enabled are dropped
	// write only when disabled
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			timing_reg <= SCL_TIMING_CONTROL_RST;
		end else if (wr_ack && !enable &&
			AVS_ADDRESS_IN == SCL_TIMING_CONTROL_OFS) begin
			timing_reg <= AVS_WRITEDATA_IN[15:0] & TIMING_WMASK;
		end
	end

	// ----------------------------------------
	// Interrupt status: read clears, set wins
	// ----------------------------------------
	always_comb begin
		events = 4'h0;
		events[INT_STOP_BIT] = stop_det;
		events[INT_START_BIT] = start_det;
		events[INT_ADDR_BIT] = ADDR_EVENT_IN.done && enable;
		events[INT_ARB_BIT] = ARB_LOST_IN && enable;
		int_status_next = int_status_reg;
		if (rd_ack && AVS_ADDRESS_IN == INT_STATUS_OFS) begin
			int_status_next = 4'h0;
		end
		int_status_next = int_status_next | events;
	end

	// Sticky event bits
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			int_status_reg <= INT_RST;
		end else begin
			int_status_reg <= int_status_next;
		end
	end

	// Level interrupt from unmasked events
	assign IRQ_OUT = |(int_status_reg & int_mask_reg);

	// ----------------------------------------
	// Bus busy
	// ----------------------------------------
	// low line sets, stop clears
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			busy_reg <= BUS_STATE_STATUS_RST[BUSY_BIT];
		end else if (stop_det) begin
			busy_reg <= 1'b0;
		end else if (!sda_s || !scl_s) begin
			busy_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// Controller role
	// ----------------------------------------
	// start sent sets role
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			role_reg <= BUS_STATE_STATUS_RST[ROLE_BIT];
		end else if (!enable || stop_det || ARB_LOST_IN) begin
			role_reg <= 1'b0;
		end else if (START_SENT_IN) begin
			role_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// Transfer direction
	// ----------------------------------------
	// direction from R/W bit
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			dir_reg <= BUS_STATE_STATUS_RST[DIRECTION_BIT];
		end else if (!enable || stop_det || restart || ARB_LOST_IN) begin
			dir_reg <= 1'b0;
		end else if (ADDR_EVENT_IN.done) begin
			// Controller transmits on write, target on read
			dir_reg <= role_reg ? !ADDR_EVENT_IN.rw : ADDR_EVENT_IN.rw;
		end
	end

	// ----------------------------------------
	// Address hit flags (target role)
	// ----------------------------------------
	assign flag_clr = !enable || stop_det || restart;

	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			second_reg <= BUS_STATE_STATUS_RST[SECOND_HIT_BIT];
			host_reg <= BUS_STATE_STATUS_RST[HOST_HIT_BIT];
			dflt_reg <= BUS_STATE_STATUS_RST[DEFAULT_HIT_BIT];
			bcast_reg <= BUS_STATE_STATUS_RST[BCAST_HIT_BIT];
		end else if (flag_clr) begin
			second_reg <= 1'b0;
			host_reg <= 1'b0;
			dflt_reg <= 1'b0;
			bcast_reg <= 1'b0;
		end else if (ADDR_EVENT_IN.done && !role_reg) begin
			second_reg <= ADDR_EVENT_IN.second;
			host_reg <= ADDR_EVENT_IN.host &&
				ctrl_reg[CTRL_SMB_TYPE_BIT] && ctrl_reg[CTRL_ARP_BIT];
			dflt_reg <= ADDR_EVENT_IN.dflt && ctrl_reg[CTRL_ARP_BIT];
			bcast_reg <= ADDR_EVENT_IN.bcast && ctrl_reg[CTRL_BCAST_BIT];
		end
	end

	// ----------------------------------------
	// Status word assembly
	// ----------------------------------------
	// check value shown when enabled
	always_comb begin
		status = 16'h0000;
		if (ctrl_reg[CTRL_PEC_BIT]) begin
			status[PEC_LSB +: 8] = PEC_VALUE_IN;
		end
		status[SECOND_HIT_BIT] = second_reg;
		status[HOST_HIT_BIT] = host_reg;
		status[DEFAULT_HIT_BIT] = dflt_reg;
		status[BCAST_HIT_BIT] = bcast_reg;
		status[DIRECTION_BIT] = dir_reg;
		status[BUSY_BIT] = busy_reg;
		status[ROLE_BIT] = role_reg;
	end

	// ----------------------------------------
	// SCL timing
	// ----------------------------------------
	// periods
	scl_period_gen u_scl (
		.clk_in(CLK_IN),
		.nrst_in(NRST_IN),
		.run_in(enable && role_reg),
		.speed_in(timing_reg[SPEED_BIT]),
		.duty_in(timing_reg[DUTY_BIT]),
		.div_in(timing_reg[DIV_W-1:0]),
		.scl_low_out(scl_low)
	);

	// Open drain: drive low only
	assign SCL_OUT = 1'b0;
	assign SCL_OE_OUT = scl_low;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_busy_stop;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		stop_det |=> !busy_reg;
	endproperty
	a_busy_stop: assert property (p_busy_stop)
		else $error("busy not cleared by stop");

	property p_busy_low;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		(!sda_s && !stop_det) |=> busy_reg;
	endproperty
	a_busy_low: assert property (p_busy_low)
		else $error("busy not set on low line");

	property p_role_set;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		(START_SENT_IN && enable && !stop_det && !ARB_LOST_IN)
			|=> role_reg;
	endproperty
	a_role_set: assert property (p_role_set)
		else $error("role not set on start");

	property p_dir_clr;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		(ARB_LOST_IN || !enable) |=> !dir_reg;
	endproperty
	a_dir_clr: assert property (p_dir_clr)
		else $error("direction not cleared");

	property p_dir_set;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		(ADDR_EVENT_IN.done && !flag_clr && !ARB_LOST_IN && !role_reg)
			|=> dir_reg == $past(ADDR_EVENT_IN.rw);
	endproperty
	a_dir_set: assert property (p_dir_set)
		else $error("direction mismatch");

	property p_host_gate;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		$rose(host_reg) |-> $past(ctrl_reg[CTRL_ARP_BIT -: 2]) == 2'h3;
	endproperty
	a_host_gate: assert property (p_host_gate)
		else $error("host hit without resolution");

	property p_bcast_clr;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		restart |=> !bcast_reg && !second_reg && !dflt_reg;
	endproperty
	a_bcast_clr: assert property (p_bcast_clr)
		else $error("hit flag kept over restart");

	property p_pec;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		!ctrl_reg[CTRL_PEC_BIT] |-> status[15:8] == 8'h00;
	endproperty
	a_pec: assert property (p_pec)
		else $error("check value shown while off");

	property p_std_high;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		($fell(scl_low) && enable && role_reg && !timing_reg[SPEED_BIT]
			&& timing_reg[DIV_W-1:0] == 12'h004)
			|-> !scl_low [*4];
	endproperty
	a_std_high: assert property (p_std_high)
		else $error("standard high period short");

	property p_wait;
		@(posedge CLK_IN) disable iff (!NRST_IN)
		($rose(req) && !ack_reg) |=> !AVS_WAITREQUEST_OUT;
	endproperty
	a_wait: assert property (p_wait)
		else $error("waitrequest held too long");

	c_restart: cover property (@(posedge CLK_IN) restart);
	c_role: cover property (@(posedge CLK_IN) $rose(role_reg));
	c_irq: cover property (@(posedge CLK_IN) $rose(IRQ_OUT));
endmodule

/* bench/i2c_far_end.sv */
`timescale 1ns/1ps
module i2c_far_end (
	// Clock
	input wire logic clk_in,
	// Block pulling SCL low
	input wire logic scl_oe_in,
	// Wire levels, both lines pulled up
	output logic sda_out,
	output logic scl_out
);
	// ----------------------------------------
	// Open-drain lines
	// ----------------------------------------
	logic sda_rel; // 1 = this end lets SDA float high
	logic scl_rel; // 1 = this end lets SCL float high
	initial begin
		sda_rel = 1'b1;
		scl_rel = 1'b1;
	end
	// Wired-AND with the pull-up; a released line reads high
	assign sda_out = sda_rel;
	assign scl_out = scl_rel & ~scl_oe_in;
	// One line change, then settle a few clocks past the synchroniser
	task automatic step(input logic d, input logic c);
		@(posedge clk_in);
		sda_rel <= d;
		scl_rel <= c;
		repeat (3) @(posedge clk_in);
	endtask
	// SDA falls while SCL high, then SCL held low
	task automatic start_cond();
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
		step(1'b0, 1'b1);
		step(1'b0, 1'b0);
	endtask
	// SDA rises while SCL high, both then released
	task automatic stop_cond();
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
	endtask
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
	import i2c_stat_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk, nrst, rd_en, wr_en, waitreq, irq, sda, scl, scl_oe;
	logic start_sent, arb_lost, scl_do;
	logic [7:0] addr, pec;
	logic [31:0] wdata, rdata, q;
	addr_event_t ev;
	int miscompares, tests_run;
	i2c_status_timing u_dut (.CLK_IN(clk), .NRST_IN(nrst),
		.AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd_en), .AVS_WRITE_IN(wr_en),
		.AVS_WRITEDATA_IN(wdata), .AVS_READDATA_OUT(rdata),
		.AVS_WAITREQUEST_OUT(waitreq), .IRQ_OUT(irq), .SDA_IN(sda),
		.SCL_IN(scl), .SCL_OUT(scl_do), .SCL_OE_OUT(scl_oe),
		.ADDR_EVENT_IN(ev),
		.START_SENT_IN(start_sent), .ARB_LOST_IN(arb_lost),
		.PEC_VALUE_IN(pec));
	i2c_far_end u_far (.clk_in(clk), .scl_oe_in(scl_oe), .sda_out(sda),
		.scl_out(scl));
	// 100 ns clock, an integer multiple of 10 MHz
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, exp, input string what);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// One Avalon cycle, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= w;
		rd_en <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		if (n >= 50) chk(1, 0, "bus timeout");
		q = rdata;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
			input string what);
		bus(1'b0, a, 32'h0);
		chk(q & m, e, what);
	endtask
	// One-cycle address report from the byte engine
	task automatic addr_done(input logic [4:0] f);
		@(posedge clk);
		ev <= {1'b1, f};
		@(posedge clk);
		ev <= '0;
		repeat (2) @(posedge clk);
	endtask
	// Count own low and high phases of one SCL period
	task automatic meas(output int lo, output int hi);
		int n;
		n = 0;
		lo = 0;
		hi = 0;
		while (scl_oe !== 1'b0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		while (scl_oe !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		while (scl_oe === 1'b1 && lo < 100) begin
			@(posedge clk);
			lo++;
		end
		while (scl_oe === 1'b0 && hi < 100) begin
			@(posedge clk);
			hi++;
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_reset();
		rd(BUS_STATE_STATUS_OFS, '1, 32'h2, "status reset");
		rd(SCL_TIMING_CONTROL_OFS, '1, 32'h0, "timing reset");
		rd(8'h40, '1, 32'h0, "unmapped read");
		bus(1'b1, BUS_STATE_STATUS_OFS, 32'hFFFF);
		rd(BUS_STATE_STATUS_OFS, '1, 32'h2, "status read only");
		$display("test_reset done");
	endtask
	task automatic test_busy();
		bus(1'b1, INT_MASK_OFS, 32'h1);
		u_far.stop_cond();
		rd(BUS_STATE_STATUS_OFS, 32'h2, 32'h0, "busy off at stop");
		chk(irq, 1'b1, "irq on stop");
		rd(INT_STATUS_OFS, 32'h1, 32'h1, "stop event");
		chk(irq, 1'b0, "irq after clear");
		bus(1'b1, INT_MASK_OFS, 32'h0);
		u_far.start_cond();
		rd(BUS_STATE_STATUS_OFS, 32'h2, 32'h2, "busy on low");
		u_far.stop_cond();
		rd(BUS_STATE_STATUS_OFS, 32'h2, 32'h0, "busy clears");
		chk(irq, 1'b0, "irq masked");
		bus(1'b0, INT_STATUS_OFS, 32'h0);
		$display("test_busy done");
	endtask
	task automatic test_target();
		bus(1'b1, CTRL_OFS, 32'h1F);
		u_far.start_cond();
		addr_done(5'h1F);
		rd(BUS_STATE_STATUS_OFS, '1, 32'hA5F6, "all hits");
		u_far.start_cond();
		rd(BUS_STATE_STATUS_OFS, '1, 32'hA502, "restart clr");
		bus(1'b1, CTRL_OFS, 32'h03);
		addr_done(5'h0F);
		rd(BUS_STATE_STATUS_OFS, '1, 32'hA582, "gated hits");
		u_far.stop_cond();
		bus(1'b1, CTRL_OFS, 32'h09);
		rd(BUS_STATE_STATUS_OFS, '1, 32'h0000, "stop clr");
		u_far.start_cond();
		addr_done(5'h1F);
		rd(BUS_STATE_STATUS_OFS, '1, 32'h00A6, "default hit");
		bus(1'b1, CTRL_OFS, 32'h00);
		rd(BUS_STATE_STATUS_OFS, '1, 32'h0002, "disable clr");
		u_far.stop_cond();
		$display("test_target done");
	endtask
	task automatic test_timing();
		// Divider at or above the legal minimum per mode
		logic [15:0] w[3] = '{16'h0004, 16'h8002, 16'hF001};
		int lo_e[3] = '{4, 4, 16};
		int hi_e[3] = '{4, 2, 9};
		int lo, hi;
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, CTRL_OFS, 32'h0);
			// Timing written only while disabled
			bus(1'b1, SCL_TIMING_CONTROL_OFS, {16'h0, w[i]});
			rd(SCL_TIMING_CONTROL_OFS, '1, {16'h0, w[i] & TIMING_WMASK},
				"timing rw");
			bus(1'b1, CTRL_OFS, 32'h1);
			@(posedge clk);
			start_sent <= 1'b1;
			@(posedge clk);
			start_sent <= 1'b0;
			rd(BUS_STATE_STATUS_OFS, 32'h1, 32'h1, "role set");
			meas(lo, hi);
			chk(lo, lo_e[i], "scl low");
			chk(hi, hi_e[i], "scl high");
			chk(scl_do, 1'b0, "scl drive level");
			addr_done(5'h00);
			rd(BUS_STATE_STATUS_OFS, 32'h5, 32'h5, "ctl dir");
			@(posedge clk);
			arb_lost <= 1'b1;
			@(posedge clk);
			arb_lost <= 1'b0;
			rd(BUS_STATE_STATUS_OFS, 32'h5, 32'h0, "arb loss");
			repeat (40) @(posedge clk);
			chk(scl_oe, 1'b0, "scl stopped");
			u_far.stop_cond();
		end
		$display("test_timing done");
	endtask
	// ----------------------------------------
	// Verdict and run control
	// ----------------------------------------
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Watchdog, far beyond the several hundred cycles the tests need
	initial begin
		#5000000;
		miscompares++;
		$display("ERROR %0t: watchdog expired", $time);
		end_sim();
	end
	initial begin
		miscompares = 0;
		tests_run = 0;
		nrst = 1'b0;
		rd_en = 1'b0;
		wr_en = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		ev = '0;
		start_sent = 1'b0;
		arb_lost = 1'b0;
		pec = 8'hA5;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		test_reset();
		test_busy();
		test_target();
		test_timing();
		end_sim();
	end
endmodule
